// >>> core/ocd_pkg.sv
// Constants for the oscillator and protection configuration decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ocd_pkg;
	// ==========================================================
	// Register offsets (chosen, APB byte addresses)
	localparam logic [7:0] OFS_OSC_SEL = 8'h00;
	localparam logic [7:0] OFS_PROT = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RELOAD = 8'h0c;
	// ==========================================================
	// Field positions in the oscillator-selection word, and CP_BIT in the protection word
	localparam int SWM_HI = 15;
	localparam int SWM_LO = 14;
	localparam int SEC_XTAL_BIT = 12;
	localparam int CLOCK_OUTPUT_PIN_FN_BIT = 10;
	localparam int PRIMARY_OSCILLATOR_HI = 9;
	localparam int PRIMARY_OSCILLATOR_LO = 8;
	localparam int TWO_SPEED_BIT = 7;
	localparam int SEC_EN_BIT = 6;
	localparam int PLL_REF_BIT = 4;
	localparam int SRC_HI = 2;
	localparam int SRC_LO = 0;
	localparam int CP_BIT = 31;
	// ==========================================================
	// Reset values: an erased part reads all ones
	localparam logic [31:0] OSC_SEL_RESET = 32'hffffffff;
	localparam logic [31:0] PROT_RESET = 32'hffffffff;
	// Reserved ones expected in each word
	localparam logic [31:0] OSC_RSVD_MASK = 32'hffff2828;
	localparam logic [31:0] PROT_RSVD_MASK = 32'h7fffffff;
	// ==========================================================
	// Encodings
	localparam logic [1:0] PRIMARY_OSCILLATOR_EC = 2'h0;
	localparam logic [1:0] PRIMARY_OSCILLATOR_XT = 2'h1;
	localparam logic [1:0] PRIMARY_OSCILLATOR_HS = 2'h2;
	localparam logic [1:0] PRIMARY_OSCILLATOR_OFF = 2'h3;
	localparam logic [2:0] SRC_FRC_DIV = 3'h0;
	localparam logic [2:0] SRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRIMARY_OSCILLATOR = 3'h2;
	localparam logic [2:0] SRC_RSVD = 3'h3;
	localparam logic [2:0] SRC_SECONDARY_OSCILLATOR = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;
	// Timing: load sequence length, not referenced; OCD_LOAD runs three cycles
	localparam int LOAD_CYCLES = 2;
	typedef enum logic [1:0] {OCD_IDLE, OCD_LOAD, OCD_HOLD} ocd_state_e;
endpackage

// >>> core/ocd_word_store.sv
// Small memory holding the two configuration words, read data registered.
// Assumes writes come only from the programming port.
`timescale 1ns/10ps
module ocd_word_store #(
	parameter int WORDS = 2,
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Write port
	input wire logic wr_en,
	input wire logic [$clog2(WORDS)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic [$clog2(WORDS)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_r [WORDS];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_r[i] <= '1;
			end
		end else if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_data <= '1;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end
endmodule

// >>> core/ocd_top.sv
// Oscillator and code-protection configuration decoder.
// Assumes a programmer port loads the words and APB reads them back.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
module ocd_top (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Programmer port (same clock domain)
	input wire logic prog_we,
	input wire logic prog_sel,
	input wire logic [31:0] prog_data,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoded clock settings
	output logic clk_switch_en,
	output logic fail_safe_en,
	output logic sec_pins_crystal,
	output logic sec_ext_clock,
	output logic clock_output_pin_en,
	output logic [1:0] primary_osc_mode,
	output logic two_speed_startup_en,
	output logic secondary_osc_enable,
	output logic pll_ref_fast_rc,
	output logic [2:0] reset_clock_source,
	// Decoded protection and status
	output logic code_protect_active,
	output logic settings_valid
);
	// ==========================================================
	// Word store and load sequence
	ocd_pkg::ocd_state_e state_r;
	logic rd_idx_r;
	logic [1:0] cnt_r;
	logic [31:0] word_rd;
	logic [31:0] osc_r;
	logic [31:0] prot_r;
	logic reload_r;
	logic apb_go;
	logic decode_en;
	logic osc_rsvd_ok_r;
	logic prot_rsvd_ok_r;
	logic src_rsvd_r;

	ocd_word_store #(.WORDS(2), .WIDTH(32)) u_store (
		.clk(clk),
		.nrst(nrst),
		.wr_en(prog_we),
		.wr_addr(prog_sel),
		.wr_data(prog_data),
		.rd_addr(rd_idx_r),
		.rd_data(word_rd)
	);

	assign apb_go = psel && penable && pready;
	assign decode_en = state_r == ocd_pkg::OCD_HOLD;

	// The load runs right after reset release; a software reload request stands
	// in for a device reset and is the only other way the latched copy changes.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= ocd_pkg::OCD_LOAD;
			rd_idx_r <= 1'b0;
			cnt_r <= 2'h0;
			osc_r <= ocd_pkg::OSC_SEL_RESET;
			prot_r <= ocd_pkg::PROT_RESET;
		end else begin
			case (state_r)
				ocd_pkg::OCD_IDLE: begin
					if (reload_r) begin
						state_r <= ocd_pkg::OCD_LOAD;
						rd_idx_r <= 1'b0;
						cnt_r <= 2'h0;
					end
				end
				ocd_pkg::OCD_LOAD: begin
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == 2'h0) begin
						rd_idx_r <= 1'b1;
					end else if (cnt_r == 2'h1) begin
						osc_r <= word_rd;
					end else begin
						prot_r <= word_rd;
						state_r <= ocd_pkg::OCD_HOLD;
					end
				end
				ocd_pkg::OCD_HOLD: begin
					state_r <= ocd_pkg::OCD_IDLE;
				end
				default: begin
					state_r <= ocd_pkg::OCD_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Decode of the latched words
	// Every concern has its own register block, but all of them load in the single hold cycle,
	// so the outputs change together and then stay put until the next load.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			clk_switch_en <= 1'b0;
			fail_safe_en <= 1'b0;
		end else if (decode_en) begin
			clk_switch_en <= osc_r[ocd_pkg::SWM_LO];
			fail_safe_en <= osc_r[ocd_pkg::SWM_HI];
		end
	end

	// The two pin owners are complementary once decoded, so exactly one of them then holds the pins; reset clears both.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sec_pins_crystal <= 1'b0;
			sec_ext_clock <= 1'b0;
		end else if (decode_en) begin
			sec_pins_crystal <= osc_r[ocd_pkg::SEC_XTAL_BIT];
			sec_ext_clock <= !osc_r[ocd_pkg::SEC_XTAL_BIT];
		end
	end

	// ==========================================================
	// Clock output and primary oscillator
	// The enable is the inverse of the stored bit, so an erased part keeps the pin as plain I/O.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			clock_output_pin_en <= 1'b0;
		end else if (decode_en) begin
			clock_output_pin_en <= !osc_r[ocd_pkg::CLOCK_OUTPUT_PIN_FN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			primary_osc_mode <= ocd_pkg::PRIMARY_OSCILLATOR_OFF;
		end else if (decode_en) begin
			primary_osc_mode <= osc_r[ocd_pkg::PRIMARY_OSCILLATOR_HI:ocd_pkg::PRIMARY_OSCILLATOR_LO];
		end
	end

	// ==========================================================
	// Start-up, secondary oscillator and PLL reference
	always_ff @(posedge clk) begin
		if (!nrst) begin
			two_speed_startup_en <= 1'b0;
		end else if (decode_en) begin
			two_speed_startup_en <= osc_r[ocd_pkg::TWO_SPEED_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			secondary_osc_enable <= 1'b0;
		end else if (decode_en) begin
			secondary_osc_enable <= osc_r[ocd_pkg::SEC_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pll_ref_fast_rc <= 1'b1;
		end else if (decode_en) begin
			pll_ref_fast_rc <= osc_r[ocd_pkg::PLL_REF_BIT];
		end
	end

	// ==========================================================
	// Reset clock source and protection
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reset_clock_source <= ocd_pkg::SRC_FRC_DIV;
		end else if (decode_en) begin
			case (osc_r[ocd_pkg::SRC_HI:ocd_pkg::SRC_LO])
				ocd_pkg::SRC_PLL, ocd_pkg::SRC_PRIMARY_OSCILLATOR, ocd_pkg::SRC_SECONDARY_OSCILLATOR, ocd_pkg::SRC_LOW_POWER_INTERNAL_RC: begin
					reset_clock_source <= osc_r[ocd_pkg::SRC_HI:ocd_pkg::SRC_LO];
				end
				// A reserved 011 is undefined; it falls back to the safe fast RC.
				default: begin
					reset_clock_source <= ocd_pkg::SRC_FRC_DIV;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			code_protect_active <= 1'b0;
		end else if (decode_en) begin
			code_protect_active <= !prot_r[ocd_pkg::CP_BIT];
		end
	end

	// Valid drops at the end of the first OCD_LOAD cycle, so software can tell stale settings from fresh ones.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			settings_valid <= 1'b0;
		end else if (decode_en) begin
			settings_valid <= 1'b1;
		end else if (state_r == ocd_pkg::OCD_LOAD) begin
			settings_valid <= 1'b0;
		end
	end

	// ==========================================================
	// Status flags
	// Flags are taken in the same hold cycle as the outputs, so a read never mixes two loads.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			osc_rsvd_ok_r <= 1'b1;
			prot_rsvd_ok_r <= 1'b1;
			src_rsvd_r <= 1'b0;
		end else if (decode_en) begin
			osc_rsvd_ok_r <= (osc_r & ocd_pkg::OSC_RSVD_MASK) == ocd_pkg::OSC_RSVD_MASK;
			prot_rsvd_ok_r <= (prot_r & ocd_pkg::PROT_RSVD_MASK) == ocd_pkg::PROT_RSVD_MASK;
			src_rsvd_r <= osc_r[ocd_pkg::SRC_HI:ocd_pkg::SRC_LO] == ocd_pkg::SRC_RSVD;
		end
	end

	// ==========================================================
	// APB slave, zero wait state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reload_r <= 1'b0;
		end else begin
			reload_r <= apb_go && pwrite && paddr == ocd_pkg::OFS_RELOAD && pwdata[0];
		end
	end

	// Read data is registered in the setup cycle and stands through the access cycle.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				ocd_pkg::OFS_OSC_SEL: begin
					prdata <= osc_r;
				end
				ocd_pkg::OFS_PROT: begin
					prdata <= prot_r;
				end
				ocd_pkg::OFS_STATUS: begin
					// Reserved-bit check flags a word the programmer left malformed.
					prdata <= {28'h0000000, prot_rsvd_ok_r, osc_rsvd_ok_r, src_rsvd_r, settings_valid};
				end
				// Reload reads and unmapped offsets return zero.
				default: begin
					prdata <= 32'h00000000;
				end
			endcase
		end
	end

	// ==========================================================
	// APB error response
	// Only the reload word is writable, and it cannot be read back.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			case (paddr)
				ocd_pkg::OFS_OSC_SEL, ocd_pkg::OFS_PROT, ocd_pkg::OFS_STATUS: begin
					pslverr <= pwrite;
				end
				ocd_pkg::OFS_RELOAD: begin
					pslverr <= !pwrite;
				end
				default: begin
					pslverr <= 1'b1;
				end
			endcase
		end
	end
endmodule

// >>> tb/ocd_chk_assertions.sv
// Port checker for the configuration decoder.
// Assumes it is bound to ocd_top and sees only its ports.
`timescale 1ns/10ps
module ocd_chk (
	input wire logic clk, nrst, psel, penable, pwrite, pready, pslverr, prog_we,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata, pwdata,
	input wire logic clk_switch_en, fail_safe_en, sec_pins_crystal, sec_ext_clock, clock_output_pin_en,
	input wire logic [1:0] primary_osc_mode,
	input wire logic two_speed_startup_en, secondary_osc_enable, pll_ref_fast_rc,
	input wire logic code_protect_active, settings_valid,
	input wire logic [2:0] reset_clock_source
);
	// ==========================================================
	// Helper logic
	logic [2:0] cnt_r;
	logic dirty_r;
	wire acc = psel && penable && pready;
	wire rl = acc && pwrite && paddr == 8'h0c && pwdata[0];
	wire rd_ok = acc && !pwrite && settings_valid && !dirty_r && cnt_r == 3'h0;
	wire [12:0] dec = {clk_switch_en, fail_safe_en, sec_pins_crystal, sec_ext_clock, clock_output_pin_en,
		primary_osc_mode, two_speed_startup_en, secondary_osc_enable, pll_ref_fast_rc, reset_clock_source};
	always_ff @(posedge clk) begin
		if (!nrst) cnt_r <= 3'h0;
		else if (rl) cnt_r <= 3'h7;
		else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
	end
	// A word written but not reloaded must not reach the outputs yet.
	always_ff @(posedge clk) begin
		if (!nrst || rl) dirty_r <= 1'b0;
		else if (prog_we) dirty_r <= 1'b1;
	end
	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_reset_clear: assert property (disable iff (1'b0) !nrst |=> !settings_valid) else $error("valid in reset");
	a_rise_valid: assert property ($rose(nrst) |-> ##[1:6] settings_valid) else $error("no decode");
	a_hold_stable: assert property (settings_valid && $past(settings_valid) && cnt_r == 3'h0 |-> $stable(dec))
		else $error("settings moved");
	a_src_legal: assert property (settings_valid |-> reset_clock_source inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
		else $error("bad source");
	a_ext_clock: assert property (settings_valid |-> sec_ext_clock != sec_pins_crystal) else $error("pins");
	a_osc_readback: assert property (rd_ok && paddr == 8'h00 |-> prdata[15:14] == {fail_safe_en, clk_switch_en}
		&& prdata[9:8] == primary_osc_mode && prdata[10] != clock_output_pin_en) else $error("osc");
	a_prot_readback: assert property (rd_ok && paddr == 8'h04 |-> prdata[31] != code_protect_active)
		else $error("protect");
	a_ready_access: assert property ((psel && !penable) ##1 (psel && penable) |-> pready) else $error("late");
	a_unmapped_err: assert property (acc && paddr[7:4] != 4'h0 |-> pslverr && prdata == 32'h0) else $error("map");
	cover property (rl);
	cover property (acc && pslverr);
	cover property (settings_valid && code_protect_active);
endmodule
bind ocd_top ocd_chk ocd_chk_i (.*);

// >>> tb/ocd_prog_model.sv
// Programmer model driving the configuration write port.
// Assumes put is called just after a rising edge of clk.
`timescale 1ns/10ps
module ocd_prog_model (
	input wire logic clk,
	output logic prog_we,
	output logic prog_sel,
	output logic [31:0] prog_data
);
	initial begin
		prog_we = 1'b0;
		prog_sel = 1'b0;
		prog_data = 32'h0;
	end
	// Reserved bits are always written as ones.
	task automatic put(input logic sel, input logic [31:0] w);
		prog_we <= 1'b1;
		prog_sel <= sel;
		prog_data <= w | (sel ? 32'h7fffffff : 32'hffff2828);
		@(posedge clk);
		prog_we <= 1'b0;
		prog_data <= ~prog_data;
		@(posedge clk);
	endtask
endmodule

// >>> tb/ocd_top_test.sv
// Self-checking bench for the configuration decoder.
// Assumes the decoder, the programmer model and the checker.
`timescale 1ns/10ps
module ocd_top_test;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, prog_we, prog_sel, er;
	logic clk_switch_en, fail_safe_en, sec_pins_crystal, sec_ext_clock, clock_output_pin_en;
	logic two_speed_startup_en, secondary_osc_enable, pll_ref_fast_rc, code_protect_active, settings_valid;
	logic [1:0] primary_osc_mode;
	logic [2:0] reset_clock_source;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, prog_data, rd, w;
	logic [2:0] srcs [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3};
	int n_errors = 0;
	int checked = 0;
	wire [12:0] dec = {clk_switch_en, fail_safe_en, sec_pins_crystal, sec_ext_clock, clock_output_pin_en,
		primary_osc_mode, two_speed_startup_en, secondary_osc_enable, pll_ref_fast_rc, reset_clock_source};
	ocd_prog_model ocd_prog_model_i (.*);
	ocd_top ocd_top_i (.*);
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [12:0] exp_dec(input logic [31:0] x);
		return {x[14], x[15], x[12], !x[12], !x[10], x[9:8], x[7], x[6], x[4],
			(x[2:1] == 2'h3 || x[2:0] == 3'h3) ? 3'h0 : x[2:0]};
	endfunction
	task automatic close_out;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic rst_check;
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		chk("in reset", settings_valid, 0);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		chk("erased", dec, exp_dec(32'hffffffff));
		chk("erased cp", code_protect_active, 0);
	endtask
	// ==========================================================
	// Sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		rst_check();
		for (int i = 0; i < 8; i++) begin
			w = {16'h0, i[1:0], 1'b0, i[0], 1'b0, i[1], ~i[1:0], i[2], !i[0], 1'b0, !i[1], 1'b0, srcs[i]};
			ocd_prog_model_i.put(1'b0, w);
			ocd_prog_model_i.put(1'b1, {i[0], 31'h0});
			apb(1'b1, 8'h0c, 32'h1);
			repeat (6) @(posedge clk);
			w = w | 32'hffff2828;
			chk("decode", dec, exp_dec(w));
			chk("protect", code_protect_active, !i[0]);
			apb(1'b0, 8'h04, 0);
			chk("prot word", rd, {i[0], 31'h7fffffff});
		end
		apb(1'b0, 8'h00, 32'h0);
		chk("osc word", rd, w);
		apb(1'b0, 8'h08, 32'h0);
		chk("status", rd, 32'h0000000f);
		apb(1'b0, 8'h0c, 32'h0);
		chk("reload read err", er, 1);
		$display("decode test done");
		ocd_prog_model_i.put(1'b0, 32'h0);
		apb(1'b1, 8'h00, 32'h0);
		chk("ro err", er, 1);
		repeat (6) @(posedge clk);
		chk("hold", dec, exp_dec(w));
		apb(1'b0, 8'h00, 32'h0);
		chk("osc kept", rd, w);
		apb(1'b0, 8'h40, 0);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 0);
		$display("hold test done");
		rst_check();
		$display("reset test done");
		close_out();
	end
	initial begin
		#60000;
		n_errors++;
		close_out();
	end
endmodule
